// file: core/energize_serial_core.sv
`timescale 1ns/1ps
// Overview of operation
// - five commands told apart by clock counts
// - 1-2-2-3 routes next transfer to control register
// - 1-4-2-3 loads control register for shifting out
// - 1-4-4-3 loads data register for shifting out
// - 1-2-4-3 clears all sixteen fault bits
// - fault clear reaches every chained device together
// - 1-6-6-3 ends energize, starts chopping
// - energize phase is full on for selected time
// - chopping uses duty from bits six to four
// - timer enable low keeps outputs full on unless 1-6-6-3 arrives during energize
// - zero energize code with timer enable high starts directly in chopping
// - codes one to fifteen select listed milliseconds
// - zero duty turns output off after energize
// - duty codes give n eighths on time
// - duty is low-side on fraction per period
// - sample rising, drive falling, commit on strobe rise
// - plain transfer loads eight bits into data register
// - expired timer with enable low stays full on
module energize_serial_core #(
    parameter int unsigned MS_TICK_CYCLES = energize_pkg::MS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic load_strobe,
    input wire logic [15:0] fault_set,
    output logic serial_out,
    output logic [7:0] driver_output,
    output logic fault_active_n
);

    // ---------------- link domain ----------------
    logic [7:0] shift_reg;
    logic [15:0] edge_cnt;
    logic load_ack_tgl;
    // written by the core domain while the strobe is high; stable for
    // microseconds before the next serial clock edge
    logic load_req_tgl;
    logic [7:0] load_word;

    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            edge_cnt <= 16'h0000;
        end else begin
            edge_cnt <= edge_cnt + 16'h0001;
        end
    end

    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= 8'h00;
            load_ack_tgl <= 1'b0;
        end else if (load_req_tgl != load_ack_tgl) begin
            shift_reg <= load_word;
            load_ack_tgl <= load_req_tgl;
        end else begin
            shift_reg <= {shift_reg[6:0], serial_in};
        end
    end

    always_ff @(negedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_out <= 1'b0;
        end else begin
            serial_out <= shift_reg[7];
        end
    end

    // ---------------- core domain: strobe ----------------
    logic [2:0] strobe_sync;
    logic strobe_level;
    logic strobe_rise;
    logic snap_valid;
    logic [15:0] snap_cnt;
    logic [7:0] snap_word;

    assign strobe_rise = (strobe_sync[2] == strobe_sync[1]) && strobe_sync[2] && !strobe_level;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_sync <= 3'b000;
            strobe_level <= 1'b0;
        end else begin
            strobe_sync <= {strobe_sync[1:0], load_strobe};
            if (strobe_sync[2] == strobe_sync[1]) begin
                strobe_level <= strobe_sync[2];
            end
        end
    end

    // the link clock is stopped while the strobe is high, so the count and
    // the shifted word are static when they are taken here
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            snap_valid <= 1'b0;
            snap_cnt <= 16'h0000;
            snap_word <= 8'h00;
        end else begin
            snap_valid <= strobe_rise;
            if (strobe_rise) begin
                snap_cnt <= edge_cnt;
                snap_word <= shift_reg;
            end
        end
    end

    // ---------------- core domain: decoder ----------------
    logic [15:0] prev_cnt;
    logic [15:0] part_len;
    logic [3:0] part_code;
    logic [11:0] part_hist;
    logic [15:0] pattern;
    logic is_data;
    logic hit_wr_ctrl;
    logic hit_rd_ctrl;
    logic hit_rd_data;
    logic hit_fault_clr;
    logic hit_pwm_start;
    logic hit_any;
    energize_pkg::cmd_mode_t mode;
    logic [7:0] data_reg;
    logic [7:0] ctrl_reg;
    logic [15:0] fault_flags;
    logic pwm_start;

    // a part is the run of link clocks between two strobe rises; the last
    // four parts form the pattern, long data parts saturate their nibble
    assign part_len = snap_cnt - prev_cnt;
    assign part_code = (part_len > 16'h000f) ? energize_pkg::PART_SATURATE : part_len[3:0];
    assign pattern = {part_hist, part_code};
    assign is_data = part_len >= energize_pkg::DATA_MIN_CLOCKS;
    assign hit_wr_ctrl = snap_valid && (pattern == energize_pkg::PAT_WRITE_CTRL);
    assign hit_rd_ctrl = snap_valid && (pattern == energize_pkg::PAT_READ_CTRL);
    assign hit_rd_data = snap_valid && (pattern == energize_pkg::PAT_READ_DATA);
    assign hit_fault_clr = snap_valid && (pattern == energize_pkg::PAT_FAULT_CLEAR);
    assign hit_pwm_start = snap_valid && (pattern == energize_pkg::PAT_PWM_START);
    assign hit_any = hit_wr_ctrl | hit_rd_ctrl | hit_rd_data | hit_fault_clr | hit_pwm_start;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_cnt <= 16'h0000;
            part_hist <= 12'h000;
        end else if (snap_valid) begin
            prev_cnt <= snap_cnt;
            part_hist <= hit_any ? 12'h000 : pattern[11:0];
        end
    end

    // mode says where the next data frame goes; a readback frame commits
    // nothing and returns the mode to normal
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= energize_pkg::MODE_NORMAL;
        end else if (hit_wr_ctrl) begin
            mode <= energize_pkg::MODE_WR_CTRL;
        end else if (hit_rd_ctrl || hit_rd_data) begin
            mode <= energize_pkg::MODE_READBACK;
        end else if (snap_valid && is_data) begin
            mode <= energize_pkg::MODE_NORMAL;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_reg <= energize_pkg::DATA_RESET;
        end else if (snap_valid && !hit_any && is_data
                     && mode == energize_pkg::MODE_NORMAL) begin
            data_reg <= snap_word;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= energize_pkg::CTRL_RESET;
        end else if (snap_valid && !hit_any && is_data
                     && mode == energize_pkg::MODE_WR_CTRL) begin
            ctrl_reg <= snap_word;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            load_req_tgl <= 1'b0;
            load_word <= 8'h00;
        end else if (hit_rd_ctrl) begin
            load_word <= ctrl_reg;
            load_req_tgl <= !load_req_tgl;
        end else if (hit_rd_data) begin
            load_word <= data_reg;
            load_req_tgl <= !load_req_tgl;
        end
    end

    // a fault raised in the clearing cycle is kept
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_flags <= energize_pkg::FAULT_RESET_VALUE;
            fault_active_n <= 1'b1;
        end else begin
            fault_flags <= (hit_fault_clr ? energize_pkg::FAULT_RESET_VALUE : fault_flags)
                           | fault_set;
            fault_active_n <= ~(|fault_flags);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_start <= 1'b0;
        end else begin
            pwm_start <= hit_pwm_start;
        end
    end

    // ---------------- core domain: timing bases ----------------
    logic [15:0] slot_div;
    logic [2:0] slot;

    // one pwm period is eight equal slots shared by all channels, so a
    // duty code n keeps the output on for the first n slots of each period
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_div <= 16'h0000;
            slot <= 3'h0;
        end else if (slot_div == 16'(energize_pkg::PWM_SLOT_CYCLES - 1)) begin
            slot_div <= 16'h0000;
            slot <= slot + 3'h1;
        end else begin
            slot_div <= slot_div + 16'h0001;
        end
    end

    // ---------------- core domain: channels ----------------
    logic timer_en;
    logic [2:0] duty;
    logic [3:0] etime;
    logic [8:0] etime_ms;
    energize_pkg::out_phase_t phase [8];
    energize_pkg::out_phase_t chop_or_dark;
    logic [7:0] next_drive;

    assign timer_en = ctrl_reg[energize_pkg::CTRL_TIMER_EN_BIT];
    assign duty = ctrl_reg[energize_pkg::CTRL_DUTY_MSB:energize_pkg::CTRL_DUTY_LSB];
    assign etime = ctrl_reg[energize_pkg::CTRL_ETIME_MSB:energize_pkg::CTRL_ETIME_LSB];
    assign etime_ms = energize_pkg::energize_ms(etime);
    assign chop_or_dark = (duty == 3'h0) ? energize_pkg::PH_DARK : energize_pkg::PH_CHOP;

    for (genvar i = 0; i < energize_pkg::CHANNELS; i++) begin : g_chan
        logic [8:0] timer_ms;
        logic [31:0] ms_div;
        logic ms_tick;
        logic expired;

        assign expired = (etime != 4'h0) && (timer_ms >= etime_ms);

        // own divider per channel: the energize time runs from this
        // channel's turn-on, not from a tick shared with the others
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                ms_div <= 32'h0000_0000;
                ms_tick <= 1'b0;
            end else if (phase[i] != energize_pkg::PH_ENERGIZE) begin
                ms_div <= 32'h0000_0000;
                ms_tick <= 1'b0;
            end else if (ms_div >= MS_TICK_CYCLES - 1) begin
                ms_div <= 32'h0000_0000;
                ms_tick <= 1'b1;
            end else begin
                ms_div <= ms_div + 32'h0000_0001;
                ms_tick <= 1'b0;
            end
        end

        // whole milliseconds spent in energize; saturates so that a long
        // full-on hold never wraps back below the limit
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                timer_ms <= 9'h000;
            end else if (phase[i] != energize_pkg::PH_ENERGIZE) begin
                timer_ms <= 9'h000;
            end else if (ms_tick && timer_ms != 9'h1ff) begin
                timer_ms <= timer_ms + 9'h001;
            end
        end

        // off -> energize, or straight to chop or dark; the later phases
        // stay until the data bit drops, control changes apply live
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                phase[i] <= energize_pkg::PH_OFF;
            end else if (!data_reg[i]) begin
                phase[i] <= energize_pkg::PH_OFF;
            end else begin
                unique case (phase[i])
                    energize_pkg::PH_OFF: begin
                        if (timer_en && etime == 4'h0) begin
                            phase[i] <= chop_or_dark;
                        end else begin
                            phase[i] <= energize_pkg::PH_ENERGIZE;
                        end
                    end
                    energize_pkg::PH_ENERGIZE: begin
                        if (pwm_start) begin
                            phase[i] <= chop_or_dark;
                        end else if (expired && timer_en) begin
                            phase[i] <= chop_or_dark;
                        end else if (expired) begin
                            phase[i] <= energize_pkg::PH_HOLD;
                        end
                    end
                    energize_pkg::PH_CHOP, energize_pkg::PH_HOLD, energize_pkg::PH_DARK: begin
                        phase[i] <= phase[i];
                    end
                    default: begin
                        phase[i] <= energize_pkg::PH_OFF;
                    end
                endcase
            end
        end

        always_comb begin
            unique case (phase[i])
                energize_pkg::PH_ENERGIZE: next_drive[i] = 1'b1;
                energize_pkg::PH_HOLD: next_drive[i] = 1'b1;
                energize_pkg::PH_CHOP: next_drive[i] = slot < duty;
                default: next_drive[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            driver_output <= 8'h00;
        end else begin
            driver_output <= next_drive;
        end
    end

endmodule // energize_serial_core

// file: include/energize_pkg.sv
package energize_pkg;

    localparam int CHANNELS = 8;
    localparam int FAULT_W = 16;
    localparam int EDGE_W = 16;

    // control register layout
    localparam int CTRL_TIMER_EN_BIT = 7;
    localparam int CTRL_DUTY_LSB = 4;
    localparam int CTRL_DUTY_MSB = 6;
    localparam int CTRL_ETIME_LSB = 0;
    localparam int CTRL_ETIME_MSB = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [15:0] FAULT_RESET_VALUE = 16'h0000;

    // four part clock counts, one nibble per part, part 1 in the top nibble
    localparam logic [15:0] PAT_WRITE_CTRL = 16'h1223;
    localparam logic [15:0] PAT_READ_CTRL = 16'h1423;
    localparam logic [15:0] PAT_READ_DATA = 16'h1443;
    localparam logic [15:0] PAT_FAULT_CLEAR = 16'h1243;
    localparam logic [15:0] PAT_PWM_START = 16'h1663;
    localparam logic [3:0] PART_SATURATE = 4'hf;
    // a part of at least this many clocks is a data transfer
    localparam logic [15:0] DATA_MIN_CLOCKS = 16'h0008;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int PWM_PERIOD_NS = 80_000;
    localparam int PWM_SLOTS = 8;
    localparam int PWM_SLOT_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS / PWM_SLOTS;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_WR_CTRL = 2'b01,
        MODE_READBACK = 2'b11
    } cmd_mode_t;

    typedef enum logic [2:0] {
        PH_OFF = 3'b000,
        PH_ENERGIZE = 3'b001,
        PH_CHOP = 3'b011,
        PH_HOLD = 3'b010,
        PH_DARK = 3'b110
    } out_phase_t;

    // energize time in milliseconds for each code
    function automatic logic [8:0] energize_ms(input logic [3:0] code);
        logic [8:0] ms;
        ms = 9'h000;
        case (code)
            4'h0: ms = 9'd0;
            4'h1: ms = 9'd3;
            4'h2: ms = 9'd5;
            4'h3: ms = 9'd10;
            4'h4: ms = 9'd15;
            4'h5: ms = 9'd20;
            4'h6: ms = 9'd30;
            4'h7: ms = 9'd50;
            4'h8: ms = 9'd80;
            4'h9: ms = 9'd110;
            4'ha: ms = 9'd140;
            4'hb: ms = 9'd170;
            4'hc: ms = 9'd200;
            4'hd: ms = 9'd230;
            4'he: ms = 9'd260;
            default: ms = 9'd300;
        endcase
        return ms;
    endfunction

endpackage

// file: sim/esc_monitor.sv
`timescale 1ns/1ps
module esc_monitor (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic load_strobe,
    input wire logic [15:0] fault_set,
    input wire logic serial_out,
    input wire logic [7:0] driver_output,
    input wire logic fault_active_n
);
    logic strobe_q;
    logic seen_strobe;
    logic seen_fault;
    logic [7:0] since_rise;
    // cycles since the strobe pin last rose, saturating
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_q <= 1'b0;
            seen_strobe <= 1'b0;
            seen_fault <= 1'b0;
            since_rise <= 8'hff;
        end else begin
            strobe_q <= load_strobe;
            seen_strobe <= seen_strobe | load_strobe;
            seen_fault <= seen_fault | (|fault_set);
            if (load_strobe && !strobe_q) begin
                since_rise <= 8'h00;
            end else if (since_rise != 8'hff) begin
                since_rise <= since_rise + 8'h01;
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    property p_reset_idle;
        $rose(reset_n) |-> driver_output == 8'h00 && fault_active_n && !serial_out;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    property p_idle_out;
        !seen_strobe |-> driver_output == 8'h00;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("output without commit");
    property p_fault_set;
        |fault_set |-> ##2 !fault_active_n;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not flagged");
    property p_no_fault;
        !seen_fault |-> fault_active_n;
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("fault without cause");
    property p_fault_clear;
        $rose(fault_active_n) |-> since_rise inside {[8'h03:8'h0c]} && $past(fault_set, 2) == 16'h0000;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault cleared untimely");
    property p_fault_stay;
        !fault_active_n && since_rise > 8'h0c |=> !fault_active_n [*2];
    endproperty
    a_fault_stay: assert property (p_fault_stay) else $error("fault dropped alone");
    property p_sout_edge;
        $changed(serial_out) |-> !serial_clk;
    endproperty
    a_sout_edge: assert property (p_sout_edge) else $error("output moved on rise");
    property p_sout_hold;
        load_strobe [*2] |-> $stable(serial_out);
    endproperty
    a_sout_hold: assert property (p_sout_hold) else $error("output moved in strobe");
endmodule // esc_monitor

bind energize_serial_core esc_monitor esc_monitor_i (
    .ref_clk, .reset_n, .serial_clk, .load_strobe, .fault_set,
    .serial_out, .driver_output, .fault_active_n
);

// file: sim/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    input wire logic serial_out,
    output logic serial_clk,
    output logic serial_in,
    output logic load_strobe
);
    logic [15:0] junk;
    int slow = 0;
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        load_strobe = 1'b0;
    end
    // one strobe-ended part of n clocks; clock stands still outside it
    task automatic part(input int n, input logic [15:0] din, output logic [15:0] dout);
        dout = 16'h0000;
        @(negedge ref_clk);
        #3;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = din[i];
            #16 serial_clk = 1'b1;
            dout = {dout[14:0], serial_out};
            #16 serial_clk = 1'b0;
        end
        serial_in = ~serial_in;
        #(1000 + slow) load_strobe = 1'b1;
        #2000 load_strobe = 1'b0;
        #1000;
    endtask
    // four parts whose clock counts name the command
    task automatic cmd(input logic [15:0] pat);
        for (int k = 3; k >= 0; k--) begin
            part(int'(pat[4 * k +: 4]), 16'h0000, junk);
        end
    endtask
endmodule // host_model

// file: sim/tb_energize_serial_core.sv
`timescale 1ns/1ps
module tb_energize_serial_core;
    localparam int unsigned MS = 20;
    localparam int SLOT = energize_pkg::PWM_SLOT_CYCLES;
    typedef struct packed {
        logic [7:0] din;
        logic [7:0] dout;
    } row_t;
    row_t rows [3] = '{'{8'ha5, 8'ha5}, '{8'h5a, 8'h5a}, '{8'h00, 8'h00}};
    logic [2:0] duties [2] = '{3'h1, 3'h7};
    logic [3:0] codes [2] = '{4'h1, 4'hf};
    int ms_of [2] = '{3, 300};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] fault_set = 16'h0000;
    logic serial_clk, serial_in, load_strobe, serial_out, fault_active_n;
    logic [7:0] driver_output;
    logic [15:0] w;
    int mismatches = 0;
    int n_checks = 0;
    int run = 0;
    int run0 = 0;
    int on;

    always #4 ref_clk = ~ref_clk;

    // length of the last high run of channel 0
    always @(posedge ref_clk) begin
        run <= (driver_output[0] === 1'b1) ? run + 1 : 0;
        if (driver_output[0] !== 1'b1 && run != 0) begin
            run0 <= run;
        end
    end

    energize_serial_core #(.MS_TICK_CYCLES(MS)) energize_serial_core_i (
        .ref_clk, .reset_n, .serial_clk, .serial_in, .load_strobe,
        .fault_set, .serial_out, .driver_output, .fault_active_n
    );
    host_model host_model_i (.ref_clk, .serial_out, .serial_clk, .serial_in, .load_strobe);

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_ctrl(input logic [7:0] c);
        host_model_i.cmd(energize_pkg::PAT_WRITE_CTRL);
        host_model_i.part(8, {8'h00, c}, w);
        host_model_i.cmd(energize_pkg::PAT_READ_CTRL);
        host_model_i.part(9, 16'h0000, w);
        check_val({8'h00, w[7:0]}, {8'h00, c});
    endtask
    // channel 0 off, then on again
    task automatic restart;
        host_model_i.part(8, 16'h0000, w);
        host_model_i.part(8, 16'h0001, w);
    endtask
    task automatic measure(output int cnt);
        cnt = 0;
        repeat (energize_pkg::PWM_SLOTS * SLOT) begin
            @(negedge ref_clk);
            if (driver_output[0] === 1'b1) begin
                cnt++;
            end
        end
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        check_val({7'h00, serial_out, driver_output}, 16'h0000);
        check_val({15'h0000, fault_active_n}, 16'h0001);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        $display("reset test done");
        foreach (rows[i]) begin
            host_model_i.slow = 3000 * i;
            host_model_i.part(8, {8'h00, rows[i].din}, w);
            check_val({8'h00, driver_output}, {8'h00, rows[i].dout});
            host_model_i.cmd(energize_pkg::PAT_READ_DATA);
            host_model_i.part(9, 16'h00ff, w);
            check_val({8'h00, w[7:0]}, {8'h00, rows[i].dout});
            check_val({8'h00, driver_output}, {8'h00, rows[i].dout});
            $display("row %0d done", i);
        end
        host_model_i.slow = 0;
        fault_set = 16'h8001;
        @(negedge ref_clk);
        fault_set = 16'h0000;
        repeat (3) @(negedge ref_clk);
        check_val({15'h0000, fault_active_n}, 16'h0000);
        host_model_i.cmd(16'h1253);
        check_val({15'h0000, fault_active_n}, 16'h0000);
        host_model_i.cmd(energize_pkg::PAT_FAULT_CLEAR);
        check_val({15'h0000, fault_active_n}, 16'h0001);
        $display("fault test done");
        foreach (duties[i]) begin
            wr_ctrl({1'b1, duties[i], 4'h0});
            restart();
            measure(on);
            check_count(on, int'(duties[i]) * SLOT, int'(duties[i]) * SLOT);
        end
        $display("duty test done");
        foreach (codes[i]) begin
            wr_ctrl({4'h8, codes[i]});
            restart();
            repeat (ms_of[i] * MS + 100) @(negedge ref_clk);
            check_count(run0, ms_of[i] * MS - 3, ms_of[i] * MS + 3);
        end
        $display("energize test done");
        wr_ctrl(8'haf);
        restart();
        host_model_i.cmd(energize_pkg::PAT_PWM_START);
        measure(on);
        check_count(on, 2 * SLOT, 2 * SLOT);
        $display("pwm start test done");
        finish_test();
    end

    // the tests need about 720 us; this cuts a hang short
    initial begin
        #790_000;
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // tb_energize_serial_core
